/* File: rtl/srdg_slave.sv */
// Purpose: SPI mode 3 slave exchanging 40-bit register datagrams.
// Assumes: Register file is outside; read data returns combinationally from it.
// Notes:   The three SPI input pins are sampled by i_clock through two-stage synchronisers.
`timescale 1ns/1ps
// Behaviour
// - Datagram is 40 bits: address byte then 32-bit data word.
// - Bit 39 selects write (1) or read (0); seven address bits follow.
// - Reply always shifted; after a read it carries that address's content.
// - After a write the reply carries the previously received write data.
// - Read dummy data is never stored; result returns on next datagram.
// - Reply bits 39..32 carry the status byte.
// - Status byte captured at end of each access, shown next transfer.
// - Status: bit7 zero, bits6..5 left stops, bits4..3 velocity reached.
// - Status bits2..1 driver faults, bit0 reset flag; cleared by status read.
// - Data words are right aligned, two's complement where signed.
// - Chip select active low, held low for the whole transaction.
// - MSB first; sample on rising bus clock, drive after falling edge.
// - Surplus input bits reappear on serial output 40 clocks later.
// - Chip select rising edge executes the last 40 bits received.
// - Bus clock idles high between transactions.
// - Reset flag set after device reset, cleared by status register read.
module srdg_slave (
  // System
  input  wire logic                    i_clock,
  input  wire logic                    i_reset,
  // SPI pins
  input  wire logic                    i_sck,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_sdi,
  output logic                         o_sdo,
  // Register side
  output logic                         o_cmd_valid,
  output srdg_pkg::srdg_cmd_type       o_cmd,
  input  wire logic [31:0]             i_read_data,
  // Status sources
  input  wire srdg_pkg::srdg_flags_type i_flags,
  output logic [7:0]                   o_global_status_flags
);
  import srdg_pkg::*;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [1:0] sck_sync;
  logic [1:0] cs_sync;
  logic [1:0] sdi_sync;
  logic       sck_prev;
  logic       cs_prev;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sck_sync <= 2'h3;
      cs_sync  <= 2'h3;
      sdi_sync <= 2'h0;
      sck_prev <= 1'b1;
      cs_prev  <= 1'b1;
    end else begin
      sck_sync <= {sck_sync[0], i_sck};
      cs_sync  <= {cs_sync[0], i_cs_n};
      sdi_sync <= {sdi_sync[0], i_sdi};
      sck_prev <= sck_sync[1];
      cs_prev  <= cs_sync[1];
    end
  end

  wire sck_s    = sck_sync[1];
  wire cs_s     = cs_sync[1];
  wire sdi_s    = sdi_sync[1];
  wire selected = ~cs_s;
  wire sck_rise = selected & sck_s & ~sck_prev;
  wire sck_fall = selected & ~sck_s & sck_prev;
  wire cs_rise  = cs_s & ~cs_prev;
  wire cs_fall  = ~cs_s & cs_prev;

  // ------------------------------------------------------------
  // Shift path and state
  // ------------------------------------------------------------
  srdg_state_type state;
  srdg_state_type next_state;
  logic [39:0]    shreg;
  logic [5:0]     bit_count;
  logic           last_write;
  logic [31:0]    last_wdata;
  logic [7:0]     status_latch;
  logic [7:0]     gflags;
  logic           sdo;
  logic           cmd_valid;
  srdg_cmd_type   cmd;

  // The reply is loaded at chip select fall from what the previous datagram left.
  wire [31:0] reply_data = last_write ? last_wdata : i_read_data;
  wire [39:0] reply_word = {status_latch, reply_data};
  wire        full       = (bit_count == CNT_FULL);
  wire [5:0]  count_inc  = full ? bit_count : bit_count + 6'h01;
  // Only the last 40 bits before chip select rises form the command; the
  // saturating counter only tells whether at least 40 of them arrived.
  wire        frame_done  = cs_rise & full;
  wire        status_read = cmd_valid & ~cmd.write & (cmd.addr == STATUS_REG_ADDR);
  wire [31:0] cmd_data_in = shreg[DIR_POS] ? shreg[DATA_BITS-1:0] : 32'h0000_0000;
  wire [7:0]  live_status = {1'b0, i_flags.stop_left, i_flags.vel_reached,
                             gflags[2:0]};
  // A fault in the cycle of a clearing read survives: the set wins.
  wire [1:0]  drv_err_kept = status_read ? 2'h0 : gflags[2:1];
  wire        reset_kept   = status_read ? 1'b0 : gflags[0];
  wire [7:0]  next_gflags  = {5'h00, drv_err_kept | i_flags.drv_err, reset_kept};

  always_comb begin
    next_state = state;
    case (state)
      SRDG_IDLE:  if (cs_fall) next_state = SRDG_SHIFT;
      SRDG_SHIFT: if (cs_rise) next_state = SRDG_EXEC;
      SRDG_EXEC:  next_state = SRDG_IDLE;
      default:    next_state = SRDG_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state     <= SRDG_IDLE;
      shreg     <= 40'h00_0000_0000;
      bit_count <= 6'h00;
      sdo       <= 1'b1;
    end else begin
      state <= next_state;
      if (cs_fall) begin
        shreg     <= reply_word;
        bit_count <= 6'h00;
        sdo       <= reply_word[39];
      end else if (sck_rise) begin
        // One 40-bit register serves reply and delay line.
        shreg     <= {shreg[38:0], sdi_s};
        bit_count <= count_inc;
      end else if (sck_fall) begin
        sdo <= shreg[39];
      end
    end
  end

  // ------------------------------------------------------------
  // Command execution and status
  // ------------------------------------------------------------
  // A frame with fewer than 40 clocks is a host error and is dropped whole,
  // so a torn command never reaches the register side.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cmd_valid <= 1'b0;
      cmd       <= '0;
    end else begin
      cmd_valid <= frame_done;
      if (frame_done) begin
        cmd.write <= shreg[DIR_POS];
        cmd.addr  <= shreg[ADDR_HI:ADDR_LO];
        cmd.data  <= cmd_data_in;
      end
    end
  end

  // The echo keeps its own copy of the write word, so the register side may
  // change its read data while a write is still to be echoed.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      last_write <= 1'b0;
      last_wdata <= 32'h0000_0000;
    end else if (frame_done) begin
      last_write <= shreg[DIR_POS];
      last_wdata <= shreg[DATA_BITS-1:0];
    end
  end

  // Driver faults are sticky until a read of the status register clears them.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      gflags <= STAT_RESET;
    end else begin
      gflags <= next_gflags;
    end
  end

  // The byte is latched at the same edge that applies a clearing read, so it
  // still shows the flags as they stood before that read.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      status_latch <= STAT_RESET;
    end else if (state == SRDG_EXEC) begin
      status_latch <= live_status;
    end
  end

  // Every output is a register; a read command carries zero data.
  assign o_sdo                 = sdo;
  assign o_cmd_valid           = cmd_valid;
  assign o_cmd                 = cmd;
  assign o_global_status_flags = gflags;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_frame_end;
    cs_rise && full;
  endsequence

  AST_EXEC_ON_RISE: assert property (@(posedge i_clock) disable iff (i_reset)
    s_frame_end |=> cmd_valid && cmd.write == $past(shreg[39]))
    else $error("Command not issued on chip select rise");
  AST_NO_SHORT: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_rise && !full |=> !cmd_valid) else $error("Short frame executed");
  AST_STATUS_TOP: assert property (@(posedge i_clock) disable iff (i_reset)
    state == SRDG_EXEC |=> status_latch[7] == 1'b0
      && status_latch[6:3] == $past({i_flags.stop_left, i_flags.vel_reached}))
    else $error("Status byte layout wrong");
  AST_REPLY_LOAD: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_fall |=> shreg[39:32] == $past(status_latch)) else $error("Status not in reply");
  AST_ECHO_WRITE: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_fall && last_write |=> shreg[31:0] == $past(last_wdata)) else $error("Write echo wrong");
  AST_STATUS_LATCH: assert property (@(posedge i_clock) disable iff (i_reset)
    state == SRDG_EXEC |=> status_latch == $past(live_status)) else $error("Status not latched");
  AST_STATUS_CLEAR: assert property (@(posedge i_clock) disable iff (i_reset)
    status_read |=> gflags[0] == 1'b0 && gflags[2:1] == $past(i_flags.drv_err))
    else $error("Status flags not cleared by a status read");
  AST_SHIFT_IN: assert property (@(posedge i_clock) disable iff (i_reset)
    sck_rise && !cs_fall |=> shreg[0] == $past(sdi_s)) else $error("Input bit not sampled");
  AST_IDLE_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_s && !cs_rise |=> $stable(shreg)) else $error("Shift while deselected");

  // ------------------------------------------------------------
  // Checks on command form and sequencing
  // ------------------------------------------------------------
  sequence s_read_end;
    cs_rise && full && !shreg[DIR_POS];
  endsequence

  sequence s_write_end;
    cs_rise && full && shreg[DIR_POS];
  endsequence

  // After a chip select rise the machine spends one cycle executing, then idles.
  sequence s_exec_tail;
    state == SRDG_EXEC ##1 state == SRDG_IDLE;
  endsequence

  AST_READ_NO_STORE: assert property (@(posedge i_clock) disable iff (i_reset)
    s_read_end |=> cmd_valid && !cmd.write && cmd.data == 32'h0000_0000)
    else $error("Read dummy data passed on as a command");

  AST_WRITE_CAPTURE: assert property (@(posedge i_clock) disable iff (i_reset)
    s_write_end |=> cmd.write && cmd.data == $past(shreg[DATA_BITS-1:0])
      && cmd.addr == $past(shreg[ADDR_HI:ADDR_LO]))
    else $error("Write command fields do not match the last 40 bits");

  AST_CMD_PULSE: assert property (@(posedge i_clock) disable iff (i_reset)
    cmd_valid |=> !cmd_valid)
    else $error("Command strobe longer than one cycle");

  AST_EXEC_STEPS: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_rise && state == SRDG_SHIFT |=> s_exec_tail)
    else $error("Frame end did not pass through execution");

  // ------------------------------------------------------------
  // Checks on the reply path and the delay line
  // ------------------------------------------------------------
  AST_REPLY_READ: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_fall && !last_write |=> shreg[DATA_BITS-1:0] == $past(i_read_data))
    else $error("Read data not loaded into the reply");

  AST_SDO_LOAD: assert property (@(posedge i_clock) disable iff (i_reset)
    cs_fall |=> sdo == $past(status_latch[7]))
    else $error("First reply bit not presented at selection");

  AST_SDO_NEXT: assert property (@(posedge i_clock) disable iff (i_reset)
    sck_fall && !cs_fall |=> sdo == $past(shreg[DIR_POS]))
    else $error("Serial output not updated after falling clock");

  // Surplus bits walk through the same register that held the reply.
  AST_DELAY_LINE: assert property (@(posedge i_clock) disable iff (i_reset)
    sck_rise && !cs_fall |=> shreg[39:1] == $past(shreg[38:0]))
    else $error("Shift register did not move by one place");

  // The counter saturates, so a long daisy-chain frame still counts as full.
  AST_COUNT_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
    full && !cs_fall |=> full)
    else $error("Bit counter left the full state inside a frame");

  // ------------------------------------------------------------
  // Checks on the sticky status flags
  // ------------------------------------------------------------
  // A fault that coincides with a clearing read must still be recorded.
  AST_SET_WINS: assert property (@(posedge i_clock) disable iff (i_reset)
    (|i_flags.drv_err) |=> (gflags[2:1] & $past(i_flags.drv_err)) == $past(i_flags.drv_err))
    else $error("Driver fault not recorded");

  AST_FLAGS_STICKY: assert property (@(posedge i_clock) disable iff (i_reset)
    !status_read |=> (gflags[2:1] & $past(gflags[2:1])) == $past(gflags[2:1]))
    else $error("Driver fault flag lost without a status read");

  AST_RESET_FLAG_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
    !status_read |=> gflags[0] == $past(gflags[0]))
    else $error("Reset flag changed without a status read");
endmodule

/* File: rtl/srdg_pkg.sv */
// Purpose: Shared constants and types for the SPI register datagram slave.
// Assumes: 100 MHz system clock; bus clock sampled, at most an eighth of that rate.
// Notes:   Offsets and widths are fixed; no parameters change structure.
package srdg_pkg;
  localparam int unsigned DGRAM_BITS = 40;
  localparam int unsigned DATA_BITS  = 32;
  localparam int unsigned ADDR_BITS  = 7;
  localparam int unsigned DIR_POS    = 39;
  localparam int unsigned STAT_HI    = 39;
  localparam int unsigned STAT_LO    = 32;
  localparam int unsigned ADDR_HI    = 38;
  localparam int unsigned ADDR_LO    = 32;
  localparam logic [6:0] STATUS_REG_ADDR = 7'h01;
  localparam logic [5:0] CNT_FULL    = 6'h28;
  localparam logic [7:0] STAT_RESET  = 8'h01;

  typedef struct packed {
    logic                 write;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } srdg_cmd_type;

  typedef struct packed {
    logic [1:0] stop_left;
    logic [1:0] vel_reached;
    logic [1:0] drv_err;
  } srdg_flags_type;

  typedef enum logic [2:0] {
    SRDG_IDLE  = 3'b001,
    SRDG_SHIFT = 3'b010,
    SRDG_EXEC  = 3'b100
  } srdg_state_type;
endpackage

/* File: sim/srdg_host.sv */
// Purpose: SPI mode 3 master model that drives datagrams into the slave.
// Assumes: Bus clock period 80 ns; the bench calls xfer just after a clock edge.
// Notes:   The data line shows the inverted last bit while deselected.
`timescale 1ns/1ps
module srdg_host (
  // Bus pins
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  initial begin
    o_sck  = 1'b1;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // Each bit is set while the clock is low so that it is stable at the rising edge.
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = 48'h0;
    o_cs_n = 1'b0;
    #80;
    for (int k = n - 1; k >= 0; k--) begin
      o_sck = 1'b0;
      o_sdi = tx[k];
      #40;
      o_sck = 1'b1;
      rx = {rx[46:0], i_sdo};
      #40;
    end
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi;
    #200;
  endtask
endmodule

/* File: sim/srdg_slave_bench.sv */
// Purpose: Self-checking bench for the SPI datagram slave.
// Assumes: Register file is modelled here; read data follows the last read address.
// Notes:   Flags are held steady except for one driver fault pulse.
`timescale 1ns/1ps
module srdg_slave_bench;
  import srdg_pkg::*;
  logic           i_clock = 1'b0;
  logic           i_reset = 1'b1;
  logic           sck, cs_n, sdi, sdo, cmd_valid;
  srdg_cmd_type   cmd;
  srdg_cmd_type   last_cmd = '0;
  srdg_flags_type flags = '{stop_left: 2'b10, vel_reached: 2'b01, drv_err: 2'b00};
  logic [7:0]     gsf;
  logic [31:0]    regs [128] = '{default: 32'h0};
  logic [6:0]     rd_addr = 7'h00;
  logic [47:0]    rx;
  int             n_cmd = 0;
  int             mismatches = 0;
  int             tests_run = 0;
  wire [31:0]     rdata = regs[rd_addr];

  srdg_slave i_srdg_slave (.i_clock(i_clock), .i_reset(i_reset), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .i_read_data(rdata), .i_flags(flags),
    .o_global_status_flags(gsf));
  srdg_host i_srdg_host (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

  initial forever #5 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    if (cmd_valid === 1'b1) begin
      n_cmd <= n_cmd + 1;
      last_cmd <= cmd;
      if (cmd.write) regs[cmd.addr] <= cmd.data;
      else rd_addr <= cmd.addr;
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input int n, input logic [47:0] tx);
    i_srdg_host.xfer(n, tx, rx);
    $display("Frame %h of %0d bits done.", tx, n);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d.", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clock);
    #1 i_reset = 1'b0;
    chk({40'h0, gsf}, 48'h01);
    repeat (3) @(posedge i_clock);
    #1;
    frame(40, 48'h85_00AB_CDEF);
    chk({n_cmd[7:0], last_cmd}, {8'h01, 1'b1, 7'h05, 32'h00AB_CDEF});
    frame(40, 48'h05_0000_0000);
    chk(rx, {8'h0, 8'h49, 32'h00AB_CDEF});
    frame(40, 48'h05_FFFF_FFFF);
    chk(rx, {8'h0, 8'h49, 32'h00AB_CDEF});
    chk({8'h0, last_cmd}, {8'h0, 1'b0, 7'h05, 32'h0});
    frame(40, 48'h01_0000_0000);
    chk(rx, {8'h0, 8'h49, 32'h00AB_CDEF});
    chk({40'h0, gsf}, 48'h00);
    flags.drv_err = 2'b01;
    repeat (2) @(posedge i_clock);
    #1 flags.drv_err = 2'b00;
    repeat (2) @(posedge i_clock);
    #1;
    chk({40'h0, gsf}, 48'h02);
    // Eight surplus bits lead the frame, so they must come back after the reply.
    frame(48, 48'hC3_85_1234_5678);
    chk(rx, {8'h49, 32'h0, 8'hC3});
    chk({n_cmd[7:0], last_cmd}, {8'h05, 1'b1, 7'h05, 32'h1234_5678});
    frame(20, 48'h0);
    chk({40'h0, n_cmd[7:0]}, 48'h05);
    frame(40, 48'h05_0000_0000);
    chk(rx, {8'h0, 8'h4A, 32'h1234_5678});
    end_of_test();
  end

  // A full run takes about 24 us; four times that means a hang.
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
